// File: lss_consts.vh
// Constants for the LED sink serial latch controller.
`ifndef LSS_CONSTS_VH
`define LSS_CONSTS_VH
`define LSS_CHAIN_W        49
`define LSS_CHAN_W         48
`define LSS_CHAIN_MSB      48
`define LSS_CMD_HI         47
`define LSS_CMD_LO         40
`define LSS_CMD_CODE       8'h96
`define LSS_FUNC_HI        39
`define LSS_FUNC_LO        3
`define LSS_FUNC_W         37
`define LSS_MC_HI          2
`define LSS_MC_LO          0
`define LSS_RED_HI         9
`define LSS_RED_LO         3
`define LSS_GRN_HI         16
`define LSS_GRN_LO         10
`define LSS_BLU_HI         23
`define LSS_BLU_LO         17
`define LSS_SLD_HI         25
`define LSS_SLD_LO         24
`define LSS_SLP_HI         27
`define LSS_SLP_LO         26
`define LSS_SEL_NONE       2'h0
`define LSS_SEL_OPEN       2'h1
`define LSS_SEL_SHORT      2'h2
`define LSS_SEL_ALWAYS     2'h3
`define LSS_MC_RESET       3'h0
`define LSS_BRIGHT_RESET   7'h00
`define LSS_FUNC_RESET     37'h0000000000
`define LSS_FIFO_W         2
`define LSS_FIFO_D         4
`define LSS_FIFO_AW        2
`endif

// File: lss_fifo.v
// Small synchronous FIFO carrying serial events in arrival order.
`timescale 1ns/100ps
`default_nettype none
module lss_fifo #(
  parameter WIDTH = 2,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk_sys,
  input  wire             arst_n,
  input  wire             clkEn,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output reg  [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_ff;
  reg [AW-1:0]    rdPtr_ff;
  reg [AW:0]      count_ff;
  wire            doPush;
  wire            doPop;

  assign inReady  = (count_ff != DEPTH[AW:0]);
  assign outValid = (count_ff != {(AW+1){1'b0}});
  assign doPush   = inValid & inReady;
  assign doPop    = outValid & outReady;

  always @* begin
    outData = mem[rdPtr_ff];
  end

  always @(posedge clk_sys) begin
    if (clkEn && doPush) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else if (clkEn) begin
      if (doPush) begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (doPop) begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
      if (doPush && !doPop) begin
        count_ff <= count_ff + 1'b1;
      end else if (doPop && !doPush) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: lss_ctrl.v
// Serial shift chain, latch decode, gating and low-power control of the LED sink.
`timescale 1ns/100ps
`default_nettype none
`include "lss_consts.vh"
module lss_ctrl (
  input  wire                    clk_sys,
  input  wire                    arst_n,
  input  wire                    clkEn,
  input  wire                    shiftClk,
  input  wire                    serialInput,
  input  wire                    transferStrobe,
  input  wire                    inhibit,
  input  wire [`LSS_CHAN_W-1:0]  openFault,
  input  wire [`LSS_CHAN_W-1:0]  shortFault,
  output reg                     serialOutput_ff,
  output reg  [`LSS_CHAN_W-1:0]  sinkChannel_ff,
  output reg  [6:0]              brightRed_ff,
  output reg  [6:0]              brightGreen_ff,
  output reg  [6:0]              brightBlue_ff,
  output reg  [2:0]              maxCurrentCode_ff,
  output reg                     lowPowerState_ff,
  output reg                     eventOverrun_ff
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. Faults come from analog comparators, so they are synchronised too.
  reg  [2:0]             sclkSync_ff;
  reg  [1:0]             sinSync_ff;
  reg  [2:0]             strbSync_ff;
  reg  [2:0]             inhSync_ff;
  reg  [`LSS_CHAN_W-1:0] openMeta_ff;
  reg  [`LSS_CHAN_W-1:0] openSync_ff;
  reg  [`LSS_CHAN_W-1:0] shortMeta_ff;
  reg  [`LSS_CHAN_W-1:0] shortSync_ff;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sclkSync_ff  <= 3'h0;
      sinSync_ff   <= 2'h0;
      strbSync_ff  <= 3'h0;
      inhSync_ff   <= 3'h7;
      openMeta_ff  <= 48'h000000000000;
      openSync_ff  <= 48'h000000000000;
      shortMeta_ff <= 48'h000000000000;
      shortSync_ff <= 48'h000000000000;
    end else if (clkEn) begin
      sclkSync_ff  <= {sclkSync_ff[1:0], shiftClk};
      sinSync_ff   <= {sinSync_ff[0], serialInput};
      strbSync_ff  <= {strbSync_ff[1:0], transferStrobe};
      inhSync_ff   <= {inhSync_ff[1:0], inhibit};
      openMeta_ff  <= openFault;
      openSync_ff  <= openMeta_ff;
      shortMeta_ff <= shortFault;
      shortSync_ff <= shortMeta_ff;
    end
  end

  wire sclkRise = sclkSync_ff[1] & ~sclkSync_ff[2];
  wire strbRise = strbSync_ff[1] & ~strbSync_ff[2];
  wire inhRise  = inhSync_ff[1] & ~inhSync_ff[2];
  wire inhLevel = inhSync_ff[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Event FIFO keeps shift bits and strobes in order, since a strobe must see every
  // earlier bit already in the chain. Bit 1 marks a strobe, bit 0 carries the data.
  wire                   evInReady;
  wire                   evOutValid;
  wire [`LSS_FIFO_W-1:0] evOutData;
  reg                    busy_ff;
  wire                   evPush = sclkRise | strbRise;
  wire [`LSS_FIFO_W-1:0] evInData = {strbRise, sinSync_ff[1]};

  lss_fifo #(
    .WIDTH (`LSS_FIFO_W),
    .DEPTH (`LSS_FIFO_D),
    .AW    (`LSS_FIFO_AW)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .clkEn    (clkEn),
    .inValid  (evPush),
    .inReady  (evInReady),
    .inData   (evInData),
    .outValid (evOutValid),
    .outReady (~busy_ff),
    .outData  (evOutData)
  );

  wire evTake   = evOutValid & ~busy_ff;
  wire doShift  = evTake & ~evOutData[1];
  wire doStrobe = evTake & evOutData[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Chain, latches and status holder.
  reg  [`LSS_CHAIN_W-1:0] chain_ff;
  reg  [`LSS_CHAN_W-1:0]  enableLatch_ff;
  reg  [`LSS_FUNC_W-1:0]  funcLatch_ff;
  reg  [2:0]              mcPending_ff;
  reg                     mcPendValid_ff;
  reg  [`LSS_CHAN_W-1:0]  statusHold_ff;
  reg                     statusArmed_ff;

  // The latch holds chain bits 39..3, so its bit 0 is field bit 0 and fields need no offset.
  wire [1:0] statusSel = funcLatch_ff[`LSS_SLD_HI:`LSS_SLD_LO];
  wire [1:0] sleepSel  = funcLatch_ff[`LSS_SLP_HI:`LSS_SLP_LO];
  wire       isEnableWr = doStrobe & ~chain_ff[`LSS_CHAIN_MSB];
  wire       cmdOk = (chain_ff[`LSS_CMD_HI:`LSS_CMD_LO] == `LSS_CMD_CODE);
  wire       isFuncWr = doStrobe & chain_ff[`LSS_CHAIN_MSB] & cmdOk;
  wire [2:0] newMc = chain_ff[`LSS_MC_HI+`LSS_FUNC_LO:`LSS_MC_LO+`LSS_FUNC_LO];
  wire       statusLoad = isEnableWr & statusArmed_ff
                          & (statusSel == `LSS_SEL_OPEN || statusSel == `LSS_SEL_SHORT);

  // The strobe takes one extra cycle so the next event sees the updated chain.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy_ff <= 1'b0;
    end else if (clkEn) begin
      busy_ff <= doStrobe;
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      chain_ff       <= 49'h0000000000000;
      enableLatch_ff <= 48'h000000000000;
      funcLatch_ff   <= `LSS_FUNC_RESET;
      mcPending_ff   <= `LSS_MC_RESET;
      mcPendValid_ff <= 1'b0;
      statusHold_ff  <= 48'h000000000000;
      statusArmed_ff <= 1'b1;
    end else if (clkEn) begin
      if (doShift) begin
        chain_ff       <= {chain_ff[`LSS_CHAIN_W-2:0], evOutData[0]};
        statusArmed_ff <= 1'b1;
      end else if (statusLoad) begin
        chain_ff[`LSS_CHAN_W-1:0] <= statusHold_ff;
        statusArmed_ff            <= 1'b0;
      end
      if (isEnableWr) begin
        enableLatch_ff <= chain_ff[`LSS_CHAN_W-1:0];
      end
      if (isFuncWr) begin
        funcLatch_ff   <= chain_ff[`LSS_FUNC_HI:`LSS_FUNC_LO];
        mcPending_ff   <= newMc;
        mcPendValid_ff <= 1'b1;
      end
      // A wrong command byte with MSB set falls through and changes nothing.
      if (inhRise && !lowPowerState_ff) begin
        if (statusSel == `LSS_SEL_OPEN) begin
          statusHold_ff <= openSync_ff;
        end else if (statusSel == `LSS_SEL_SHORT) begin
          statusHold_ff <= shortSync_ff;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Low-power state and outputs.
  reg nxt_lowPower;

  always @* begin
    nxt_lowPower = lowPowerState_ff;
    case (sleepSel)
      `LSS_SEL_NONE: nxt_lowPower = 1'b0;
      `LSS_SEL_ALWAYS: nxt_lowPower = 1'b1;
      `LSS_SEL_OPEN: begin
        if (isEnableWr && chain_ff[`LSS_CHAN_W-1:0] == 48'h000000000000) begin
          nxt_lowPower = 1'b1;
        end else if (sclkRise) begin
          nxt_lowPower = 1'b0;
        end
      end
      `LSS_SEL_SHORT: begin
        if (isEnableWr && chain_ff[`LSS_CHAN_W-1:0] == 48'h000000000000) begin
          nxt_lowPower = 1'b1;
        end else if (enableLatch_ff != 48'h000000000000 && !isEnableWr) begin
          nxt_lowPower = 1'b0;
        end
      end
      default: nxt_lowPower = lowPowerState_ff;
    endcase
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lowPowerState_ff  <= 1'b0;
      serialOutput_ff   <= 1'b0;
      sinkChannel_ff    <= 48'h000000000000;
      brightRed_ff      <= `LSS_BRIGHT_RESET;
      brightGreen_ff    <= `LSS_BRIGHT_RESET;
      brightBlue_ff     <= `LSS_BRIGHT_RESET;
      maxCurrentCode_ff <= `LSS_MC_RESET;
      eventOverrun_ff   <= 1'b0;
    end else if (clkEn) begin
      lowPowerState_ff <= nxt_lowPower;
      serialOutput_ff  <= chain_ff[`LSS_CHAIN_MSB];
      // Sinks are gated by inhibit and by low power; leaving low power restores them.
      if (inhLevel || lowPowerState_ff) begin
        sinkChannel_ff <= 48'h000000000000;
      end else begin
        sinkChannel_ff <= enableLatch_ff;
      end
      brightRed_ff   <= funcLatch_ff[`LSS_RED_HI:`LSS_RED_LO];
      brightGreen_ff <= funcLatch_ff[`LSS_GRN_HI:`LSS_GRN_LO];
      brightBlue_ff  <= funcLatch_ff[`LSS_BLU_HI:`LSS_BLU_LO];
      if (isFuncWr && mcPendValid_ff && mcPending_ff == newMc) begin
        maxCurrentCode_ff <= newMc;
      end
      // A full FIFO drops the event; the sticky flag reports it until reset.
      if (evPush && !evInReady) begin
        eventOverrun_ff <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: lss_ctrl_properties.sv
// Port-level concurrent checks for the LED sink serial latch controller.
`timescale 1ns/100ps
`default_nettype none
`include "lss_consts.vh"
module lss_ctrl_properties (
  input wire                   clk_sys,
  input wire                   arst_n,
  input wire                   shiftClk,
  input wire                   transferStrobe,
  input wire                   inhibit,
  input wire                   serialOutput_ff,
  input wire [`LSS_CHAN_W-1:0] sinkChannel_ff,
  input wire [6:0]             brightRed_ff,
  input wire [6:0]             brightGreen_ff,
  input wire [6:0]             brightBlue_ff,
  input wire [2:0]             maxCurrentCode_ff,
  input wire                   lowPowerState_ff,
  input wire                   eventOverrun_ff
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Eight quiet cycles cover the two-stage pin synchroniser and the event FIFO.
  sequence quietStrobe;
    !transferStrobe [*8];
  endsequence
  sequence quietPins;
    (!shiftClk && !transferStrobe) [*8];
  endsequence
  sequence calmSinks;
    (!transferStrobe && $stable(inhibit) && $stable(lowPowerState_ff)) [*8];
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_inhibit_forces_off: assert property (inhibit [*6] |-> sinkChannel_ff == '0)
    else $error("sink on while inhibit high");
  a_bright_needs_strobe: assert property (quietStrobe |-> $stable({brightRed_ff, brightGreen_ff, brightBlue_ff}))
    else $error("brightness changed without strobe");
  a_current_needs_strobe: assert property (quietStrobe |-> $stable(maxCurrentCode_ff))
    else $error("max current changed without strobe");
  a_sinks_need_cause: assert property (calmSinks |-> $stable(sinkChannel_ff))
    else $error("sinks changed without cause");
  a_low_power_dark: assert property (lowPowerState_ff [*3] |-> sinkChannel_ff == '0)
    else $error("sink on in low power");
  a_output_needs_edge: assert property (quietPins |-> $stable(serialOutput_ff))
    else $error("serial output moved without edge");
  a_no_event_overrun: assert property (!eventOverrun_ff)
    else $error("event overrun at nominal rate");
  a_entry_goes_dark: assert property ($rose(lowPowerState_ff) |-> ##[0:2] sinkChannel_ff == '0)
    else $error("sinks lit on low power entry");
endmodule
`default_nettype wire

// File: lss_host_model.sv
// Behavioural display controller that shifts words into the sink and strobes them.
`timescale 1ns/100ps
`default_nettype none
module lss_host_model (
  input  wire        go,
  input  wire [48:0] word,
  input  wire [5:0]  nBits,
  input  wire        doStrobe,
  output logic       shiftClk,
  output logic       serialInput,
  output logic       transferStrobe,
  output logic       busy
);
  integer i;
  // Shift clock stands low between frames; an 80 ns period keeps the FIFO clear.
  // Data turns to its inverse mid-way through the high phase, so a late sample shows up.
  initial begin
    shiftClk       = 1'b0;
    serialInput    = 1'b0;
    transferStrobe = 1'b0;
    busy           = 1'b0;
    forever begin
      @(posedge go);
      busy = 1'b1;
      #3;
      for (i = nBits - 1; i >= 0; i = i - 1) begin
        serialInput = word[i];
        #40 shiftClk = 1'b1;
        #20 serialInput = ~word[i];
        #20 shiftClk = 1'b0;
      end
      if (doStrobe) begin
        #40 transferStrobe = 1'b1;
        #40 transferStrobe = 1'b0;
      end
      #40 busy = 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking testbench for the LED sink serial latch controller.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk_sys;
  logic        arst_n;
  logic        inhibit;
  logic [47:0] openFault;
  logic [47:0] shortFault;
  logic        go;
  logic [48:0] word;
  logic [5:0]  nBits;
  logic        doStrobe;
  wire         shiftClk;
  wire         serialInput;
  wire         transferStrobe;
  wire         busy;
  wire         serial_output;
  wire  [47:0] sink;
  wire  [6:0]  bR;
  wire  [6:0]  bG;
  wire  [6:0]  bB;
  wire  [2:0]  mc;
  wire         lp;
  wire         ovr;
  integer      mismatches;
  integer      nChecks;
  integer      m;
  localparam logic [47:0] E1 = 48'hA5A50F0F1234;
  localparam logic [47:0] S1 = 48'h3C3C0000FFFF;
  lss_host_model host (.go(go), .word(word), .nBits(nBits), .doStrobe(doStrobe),
    .shiftClk(shiftClk), .serialInput(serialInput), .transferStrobe(transferStrobe), .busy(busy));
  lss_ctrl dut (.clk_sys(clk_sys), .arst_n(arst_n), .clkEn(1'b1), .shiftClk(shiftClk),
    .serialInput(serialInput), .transferStrobe(transferStrobe), .inhibit(inhibit),
    .openFault(openFault), .shortFault(shortFault), .serialOutput_ff(serial_output),
    .sinkChannel_ff(sink), .brightRed_ff(bR), .brightGreen_ff(bG), .brightBlue_ff(bB),
    .maxCurrentCode_ff(mc), .lowPowerState_ff(lp), .eventOverrun_ff(ovr));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    nChecks = nChecks + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (nChecks > 0 && mismatches == 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Function word: select bit, command byte, then fields placed three bits up.
  function automatic logic [48:0] fw(input logic [7:0] cmd, input logic [2:0] c,
    input logic [6:0] r, input logic [6:0] g, input logic [6:0] b, input logic [1:0] sld,
    input logic [1:0] slp);
    fw = {1'b1, cmd, 9'h000, slp, sld, b, g, r, c, 3'h0};
  endfunction
  // The fixed settle after the host finishes covers synchroniser, FIFO and latch stages.
  task automatic send(input logic [48:0] w, input logic [5:0] n, input logic s);
    integer k;
    word <= w;
    nBits <= n;
    doStrobe <= s;
    go <= 1'b1;
    @(posedge clk_sys);
    @(posedge clk_sys);
    go <= 1'b0;
    for (k = 0; k < 2000 && busy !== 1'b0; k = k + 1) @(posedge clk_sys);
    if (k == 2000) begin
      mismatches = mismatches + 1;
      test_done;
    end
    repeat (10) @(posedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mismatches = 0;
    nChecks = 0;
    arst_n = 1'b0;
    inhibit = 1'b1;
    openFault = 48'hC3C30000F00F;
    shortFault = 48'h3C3C0000FFFF;
    go = 1'b0;
    word = 49'h0;
    nBits = 6'h00;
    doStrobe = 1'b0;
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check(sink, 48'h0);
    check(serial_output, 48'h0);
    check(lp, 48'h0);
    inhibit <= 1'b0;
    send({1'b0, E1}, 6'h31, 1'b1);
    check(sink, E1);
    check(serial_output, 48'h0);
    inhibit <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check(sink, 48'h0);
    inhibit <= 1'b0;
    repeat (8) @(posedge clk_sys);
    check(sink, E1);
    $display("test on-off done");
    send(fw(8'h96, 3'h5, 7'h7F, 7'h00, 7'h2A, 2'h0, 2'h0), 6'h31, 1'b1);
    check({bR, bG, bB}, {7'h7F, 7'h00, 7'h2A});
    check(mc, 48'h0);
    check(serial_output, 48'h1);
    send(fw(8'h96, 3'h5, 7'h7F, 7'h00, 7'h2A, 2'h0, 2'h0), 6'h31, 1'b1);
    check(mc, 48'h5);
    send(fw(8'h95, 3'h2, 7'h01, 7'h01, 7'h01, 2'h0, 2'h0), 6'h31, 1'b1);
    check({mc, bR, bG, bB}, {3'h5, 7'h7F, 7'h00, 7'h2A});
    $display("test function done");
    send(fw(8'h96, 3'h5, 7'h7F, 7'h00, 7'h2A, 2'h1, 2'h0), 6'h31, 1'b1);
    inhibit <= 1'b1;
    repeat (8) @(posedge clk_sys);
    inhibit <= 1'b0;
    send({1'b0, E1}, 6'h31, 1'b1);
    for (m = 47; m > 43; m = m - 1) begin
      send(49'h0, 6'h01, 1'b0);
      check(serial_output, openFault[m]);
    end
    send(fw(8'h96, 3'h5, 7'h7F, 7'h00, 7'h2A, 2'h2, 2'h0), 6'h31, 1'b1);
    inhibit <= 1'b1;
    repeat (8) @(posedge clk_sys);
    inhibit <= 1'b0;
    shortFault <= 48'h5A5A00000000;
    send({1'b0, E1}, 6'h31, 1'b1);
    inhibit <= 1'b1;
    repeat (8) @(posedge clk_sys);
    inhibit <= 1'b0;
    send(49'h0, 6'h00, 1'b1);
    check(sink, S1);
    for (m = 47; m > 43; m = m - 1) begin
      send(49'h0, 6'h01, 1'b0);
      check(serial_output, S1[m]);
    end
    $display("test status done");
    send(fw(8'h96, 3'h5, 7'h7F, 7'h00, 7'h2A, 2'h0, 2'h2), 6'h31, 1'b1);
    send(49'h0, 6'h31, 1'b1);
    check(lp, 48'h1);
    check(sink, 48'h0);
    inhibit <= 1'b1;
    send({1'b0, E1}, 6'h31, 1'b1);
    check(lp, 48'h0);
    inhibit <= 1'b0;
    repeat (8) @(posedge clk_sys);
    check(sink, E1);
    send(fw(8'h96, 3'h5, 7'h7F, 7'h00, 7'h2A, 2'h0, 2'h1), 6'h31, 1'b1);
    send(49'h0, 6'h31, 1'b1);
    check(lp, 48'h1);
    send(49'h0, 6'h01, 1'b0);
    check(lp, 48'h0);
    send(fw(8'h96, 3'h5, 7'h7F, 7'h00, 7'h2A, 2'h0, 2'h3), 6'h31, 1'b1);
    send({1'b0, E1}, 6'h31, 1'b1);
    check(lp, 48'h1);
    send(fw(8'h96, 3'h5, 7'h7F, 7'h00, 7'h2A, 2'h0, 2'h0), 6'h31, 1'b1);
    send(49'h0, 6'h31, 1'b1);
    check(lp, 48'h0);
    $display("test low power done");
    test_done;
  end
endmodule
bind lss_ctrl lss_ctrl_properties chk (.*);
`default_nettype wire
